// ### rtl/ssfb_pkg.sv
// constants shared by the serial flash boot protocol block
package ssfb_pkg;

    // command codes, first byte of each sequence, except CMD_ERASE_CONF which follows CMD_ERASE_ALL
    localparam logic [7:0] CMD_PAGE_READ = 8'hFF;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
    localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
    localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
    localparam logic [7:0] CMD_READ_STAT = 8'h70;
    localparam logic [7:0] CMD_CLR_STAT = 8'h50;
    localparam logic [7:0] CMD_ID_CHECK = 8'hF5;
    localparam logic [7:0] CMD_VERSION = 8'hFB;

    // framing
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int PAGE_BYTES = 256;
    localparam logic [7:0] LAST_IDX = 8'hFF;
    localparam logic [8:0] WR_END = 9'h100;
    localparam int ID_BYTES = 7;
    localparam logic [7:0] ID_LAST = 8'h06;
    localparam logic [7:0] ID_HDR_LAST = 8'h03;
    localparam int VER_BYTES = 8;
    localparam logic [7:0] VER_LAST = 8'h07;

    // flash status byte fields
    localparam int FS_READY_BIT = 7;
    localparam int FS_ERASE_ERR_BIT = 5;
    localparam int FS_PROG_ERR_BIT = 4;

    // link status byte: identification result field
    localparam int LS_ID_LSB = 2;
    localparam logic [1:0] ID_NONE = 2'b00;
    localparam logic [1:0] ID_MISMATCH = 2'b01;
    localparam logic [1:0] ID_VERIFIED = 2'b11;

    // register port map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int CTRL_CMD_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // cycles the mode strap is allowed to settle after reset release
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR_MID, ST_ADDR_HIGH, ST_RD_FETCH, ST_RD_WAIT, ST_RD_XFER,
        ST_PG_DATA, ST_PG_WRITE, ST_PG_WAIT, ST_ER_CONF, ST_ER_WAIT, ST_ST_XFER,
        ST_ID_HDR, ST_ID_DATA, ST_VER_XFER
    } ssfb_state_e;

endpackage : ssfb_pkg

// ### rtl/ssfb_buf_if.sv
// page buffer port bundle between the protocol engine and its memory
`timescale 1ns/1ps
`default_nettype none

interface ssfb_buf_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : ssfb_buf_if

`default_nettype wire

// ### rtl/ssfb_page_mem.sv
// one-page buffer with registered read data
`timescale 1ns/1ps
`default_nettype none

module ssfb_page_mem
    import ssfb_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // buffer port
    ssfb_buf_if.mem buf_port
);

    logic [7:0] mem_ff [PAGE_BYTES];
    logic [7:0] rd_data_ff;

    // no reset on the array: contents are always written before use
    always_ff @(posedge sys_clk_in)
    begin
        if (buf_port.wr_en)
        begin
            mem_ff[buf_port.wr_addr] <= buf_port.wr_data;
        end
        if (buf_port.rd_en)
        begin
            rd_data_ff <= mem_ff[buf_port.rd_addr];
        end
    end

    assign buf_port.rd_data = rd_data_ff;

endmodule : ssfb_page_mem

`default_nettype wire

// ### rtl/ssfb_top.sv
// clock-synchronous serial flash programming protocol engine
// What this block does
// RL1 - enter mode if handshake high at reset release
// RL2 - sample incoming bits on rising transfer clock
// RL3 - drive outgoing bits on falling transfer clock
// RL4 - whole bytes, least significant bit first
// RL5 - handshake high while occupied, low otherwise
// RL6 - programmer waits for handshake low first
// RL7 - first byte of sequence is command
// RL8 - page read returns 256 bytes ascending
// RL9 - page program takes 256 bytes, writes page
// RL10 - handshake drops when next page accepted
// RL11 - erase code plus confirmation starts erase
// RL12 - handshake drops when erase completes
// RL13 - status command returns flash then link status
// RL14 - clear command clears program/erase error flags
// RL15 - handshake drops when clear finishes
// RL16 - blank flash accepts every command
// RL17 - restricted commands need matching seven-byte code
// RL18 - flash status ready, erase, program bits
// RL19 - identification field 00 unchecked, 11 verified
// RL20 - unknown command ignored, handshake back low
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ssfb_top
    import ssfb_pkg::*;
#(
    // arbitrary neutral version text, eight characters
    parameter logic [8*VER_BYTES-1:0] VERSION_TEXT = 64'h5356_3030_3030_3031
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // serial link pins
    input wire logic serial_clock_input_in,
    input wire logic serial_receive_pin_in,
    output logic serial_transmit_pin_out,
    input wire logic handshake_busy_pin_in,
    output logic handshake_busy_pin_out,
    output logic handshake_busy_pin_oe_out,
    // flash array
    output logic [23:0] flash_addr_out,
    output logic flash_rd_en_out,
    input wire logic [7:0] flash_rd_data_in,
    output logic flash_wr_en_out,
    output logic [7:0] flash_wr_data_out,
    output logic flash_erase_out,
    input wire logic flash_done_in,
    input wire logic flash_fail_in,
    input wire logic flash_blank_in,
    input wire logic [8*ID_BYTES-1:0] flash_id_code_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // mode indication
    output logic serial_mode_out
);

    // ------------------------------------------------------------
    // pin synchronisers and mode entry
    // ------------------------------------------------------------
    logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic rxd_s1_ff, rxd_s2_ff;
    logic hs_s1_ff, hs_s2_ff;
    logic [1:0] strap_cnt_ff;
    logic strap_done_ff;
    logic mode_ff;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff, rxd_s1_ff, rxd_s2_ff, hs_s1_ff, hs_s2_ff} <= 7'h7C;
        end
        else
        begin
            {sclk_s3_ff, sclk_s2_ff, sclk_s1_ff} <= {sclk_s2_ff, sclk_s1_ff, serial_clock_input_in};
            {rxd_s2_ff, rxd_s1_ff} <= {rxd_s1_ff, serial_receive_pin_in};
            {hs_s2_ff, hs_s1_ff} <= {hs_s1_ff, handshake_busy_pin_in};
        end
    end

    // the strap is caught once, a few cycles after release, never on the reset itself
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            strap_cnt_ff <= 2'h0;
            strap_done_ff <= 1'b0;
            mode_ff <= 1'b0;
        end
        else if (!strap_done_ff)
        begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == STRAP_WAIT)
            begin
                strap_done_ff <= 1'b1;
                mode_ff <= hs_s2_ff; // RL1
            end
        end
    end

    wire sclk_rise = mode_ff & sclk_s2_ff & ~sclk_s3_ff;
    wire sclk_fall = mode_ff & ~sclk_s2_ff & sclk_s3_ff;

    // ------------------------------------------------------------
    // bit engine: one counter serves both directions
    // ------------------------------------------------------------
    logic [2:0] bit_cnt_ff;
    logic [7:0] rx_sr_ff;
    logic [7:0] tx_byte_ff;
    logic tx_ff;
    logic byte_done_ff;
    wire [7:0] rx_byte = rx_sr_ff;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bit_cnt_ff <= 3'h0;
            rx_sr_ff <= 8'h00;
            tx_ff <= 1'b1;
            byte_done_ff <= 1'b0;
        end
        else
        begin
            byte_done_ff <= sclk_rise && (bit_cnt_ff == LAST_BIT);
            if (sclk_rise)
            begin
                rx_sr_ff <= {rxd_s2_ff, rx_sr_ff[7:1]}; // RL2 RL4
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (sclk_fall) tx_ff <= tx_byte_ff[bit_cnt_ff]; // RL3 RL4
        end
    end

    // ------------------------------------------------------------
    // registers and status bytes
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] rdata_ff;
    logic prog_err_ff, erase_err_ff;
    logic [1:0] id_res_ff;
    logic id_fail_ff;
    ssfb_state_e state_ff, nxt_state;
    logic [7:0] idx_ff;
    logic [8:0] wr_cnt_ff;
    logic [15:0] page_ff;
    logic [7:0] cmd_ff;
    logic frd_dly_ff;

    wire flash_ready = !(state_ff inside {ST_PG_WRITE, ST_PG_WAIT, ST_ER_WAIT});
    wire [7:0] flash_status = (8'(flash_ready) << FS_READY_BIT) | (8'(erase_err_ff) << FS_ERASE_ERR_BIT)
                            | (8'(prog_err_ff) << FS_PROG_ERR_BIT); // RL18
    wire [7:0] link_status = 8'(id_res_ff) << LS_ID_LSB; // RL19
    wire cmd_en = ctrl_ff[CTRL_CMD_EN_BIT];
    wire unlocked = flash_blank_in || (id_res_ff == ID_VERIFIED); // RL16 RL17

    wire sel_ctrl = (reg_addr_in == REG_CTRL);
    wire sel_stat = (reg_addr_in == REG_STAT);
    wire [31:0] stat_word = {14'h0000, ~handshake_busy_pin_out, mode_ff, link_status, flash_status};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_ff : (sel_stat ? stat_word : 32'h0000_0000);

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctrl_ff <= CTRL_RESET;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            if (reg_wr_in && sel_ctrl) ctrl_ff <= reg_wdata_in & CTRL_RESET;
            rdata_ff <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata_out = rdata_ff;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    function automatic logic restricted(input logic [7:0] code);
        restricted = code inside {CMD_PAGE_READ, CMD_PAGE_PROG, CMD_ERASE_ALL, CMD_CLR_STAT};
    endfunction : restricted

    ssfb_buf_if buf_bus();

    ssfb_page_mem u_page_mem (
        .sys_clk_in(sys_clk_in),
        .buf_port(buf_bus.mem)
    );

    wire id_match = (rx_byte == flash_id_code_in[8*idx_ff[2:0] +: 8]);
    wire write_rd = (state_ff == ST_PG_WRITE) && (wr_cnt_ff != WR_END);

    assign buf_bus.wr_en = (state_ff == ST_PG_DATA) && byte_done_ff; // RL9
    assign buf_bus.wr_addr = idx_ff;
    assign buf_bus.wr_data = rx_byte;
    assign buf_bus.rd_en = write_rd;
    assign buf_bus.rd_addr = wr_cnt_ff[7:0];
    assign flash_wr_data_out = buf_bus.rd_data;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (byte_done_ff && cmd_en && (unlocked || !restricted(rx_byte))) // RL7 RL17
                begin
                    case (rx_byte)
                        CMD_PAGE_READ, CMD_PAGE_PROG: nxt_state = ST_ADDR_MID;
                        CMD_ERASE_ALL: nxt_state = ST_ER_CONF;
                        CMD_READ_STAT: nxt_state = ST_ST_XFER; // RL13
                        CMD_ID_CHECK: nxt_state = ST_ID_HDR;
                        CMD_VERSION: nxt_state = ST_VER_XFER;
                        default: nxt_state = ST_IDLE; // RL20
                    endcase
                end
            end
            ST_ADDR_MID: if (byte_done_ff) nxt_state = ST_ADDR_HIGH;
            ST_ADDR_HIGH: if (byte_done_ff) nxt_state = (cmd_ff == CMD_PAGE_READ) ? ST_RD_FETCH : ST_PG_DATA;
            ST_RD_FETCH: nxt_state = ST_RD_WAIT;
            ST_RD_WAIT: nxt_state = ST_RD_XFER;
            ST_RD_XFER: if (byte_done_ff) nxt_state = (idx_ff == LAST_IDX) ? ST_IDLE : ST_RD_FETCH; // RL8
            ST_PG_DATA: if (byte_done_ff && idx_ff == LAST_IDX) nxt_state = ST_PG_WRITE;
            ST_PG_WRITE: if (wr_cnt_ff == WR_END) nxt_state = ST_PG_WAIT;
            ST_PG_WAIT: if (flash_done_in) nxt_state = ST_IDLE; // RL10
            ST_ER_CONF: if (byte_done_ff) nxt_state = (rx_byte == CMD_ERASE_CONF) ? ST_ER_WAIT : ST_IDLE; // RL11
            ST_ER_WAIT: if (flash_done_in) nxt_state = ST_IDLE; // RL12
            ST_ST_XFER: if (byte_done_ff && idx_ff != 8'h00) nxt_state = ST_IDLE;
            ST_ID_HDR: if (byte_done_ff && idx_ff == ID_HDR_LAST) nxt_state = ST_ID_DATA;
            ST_ID_DATA: if (byte_done_ff && idx_ff == ID_LAST) nxt_state = ST_IDLE;
            ST_VER_XFER: if (byte_done_ff && idx_ff == VER_LAST) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // states in which the engine stands ready for the next byte
    wire waiting = !(state_ff inside {ST_RD_FETCH, ST_RD_WAIT, ST_PG_WRITE, ST_PG_WAIT, ST_ER_WAIT});
    wire entering = (state_ff != nxt_state);
    logic busy_ff;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b1;
            {cmd_ff, idx_ff, page_ff} <= 32'h0000_0000;
            wr_cnt_ff <= 9'h000;
            tx_byte_ff <= 8'hFF;
            {prog_err_ff, erase_err_ff, id_fail_ff} <= 3'h0;
            id_res_ff <= ID_NONE;
        end
        else
        begin
            state_ff <= nxt_state;
            // busy rises with the first rising clock edge of a byte and while work is pending
            busy_ff <= !waiting || entering || byte_done_ff || (bit_cnt_ff != 3'h0); // RL5 RL6
            if (state_ff == ST_IDLE && byte_done_ff)
            begin
                cmd_ff <= rx_byte; // RL7
                idx_ff <= 8'h00;
                tx_byte_ff <= (cmd_en && rx_byte == CMD_VERSION) ? VERSION_TEXT[7:0] : flash_status;
                if (cmd_en && unlocked && rx_byte == CMD_CLR_STAT) {prog_err_ff, erase_err_ff} <= 2'h0; // RL14 RL15
                id_fail_ff <= 1'b0;
            end
            // middle address byte arrives first and is shifted down by the high byte
            if (byte_done_ff && state_ff inside {ST_ADDR_MID, ST_ADDR_HIGH}) page_ff <= {rx_byte, page_ff[15:8]};
            // flash data stands one cycle after the read strobe
            if (frd_dly_ff) tx_byte_ff <= flash_rd_data_in; // RL8
            if (byte_done_ff && state_ff inside {ST_RD_XFER, ST_PG_DATA, ST_ST_XFER, ST_ID_HDR, ST_VER_XFER})
                idx_ff <= (state_ff == ST_ID_HDR && idx_ff == ID_HDR_LAST) ? 8'h00 : idx_ff + 8'h01;
            if (byte_done_ff && state_ff == ST_ST_XFER) tx_byte_ff <= link_status; // RL13
            if (byte_done_ff && state_ff == ST_VER_XFER && idx_ff != VER_LAST)
                tx_byte_ff <= VERSION_TEXT[8*(32'(idx_ff[2:0]) + 1) +: 8];
            if (byte_done_ff && state_ff == ST_ID_DATA)
            begin
                idx_ff <= idx_ff + 8'h01;
                if (idx_ff == ID_LAST)
                    id_res_ff <= (id_fail_ff || !id_match) ? ID_MISMATCH : ID_VERIFIED; // RL17 RL19
                else if (!id_match) id_fail_ff <= 1'b1;
            end
            if (state_ff == ST_PG_DATA && nxt_state == ST_PG_WRITE) wr_cnt_ff <= 9'h000;
            else if (write_rd) wr_cnt_ff <= wr_cnt_ff + 9'h001;
            // an error sets only when an operation ends, so it never meets a clear
            if (state_ff == ST_PG_WAIT && flash_done_in && flash_fail_in) prog_err_ff <= 1'b1; // RL18
            if (state_ff == ST_ER_WAIT && flash_done_in && flash_fail_in) erase_err_ff <= 1'b1; // RL18
        end
    end

    // ------------------------------------------------------------
    // flash strobes
    // ------------------------------------------------------------
    logic [23:0] faddr_ff;
    logic frd_ff, fwr_ff, fer_ff;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            faddr_ff <= 24'h00_0000;
            {frd_ff, frd_dly_ff, fwr_ff, fer_ff} <= 4'h0;
        end
        else
        begin
            frd_ff <= (state_ff == ST_RD_FETCH); // RL8
            frd_dly_ff <= frd_ff;
            fwr_ff <= write_rd; // RL9
            fer_ff <= (state_ff == ST_ER_CONF) && (nxt_state == ST_ER_WAIT); // RL11
            if (state_ff == ST_RD_FETCH) faddr_ff <= {page_ff, idx_ff};
            else if (write_rd) faddr_ff <= {page_ff, wr_cnt_ff[7:0]};
        end
    end

    assign flash_addr_out = faddr_ff;
    assign flash_rd_en_out = frd_ff;
    assign flash_wr_en_out = fwr_ff;
    assign flash_erase_out = fer_ff;

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    assign serial_transmit_pin_out = tx_ff;
    assign handshake_busy_pin_out = busy_ff;
    assign handshake_busy_pin_oe_out = mode_ff; // RL1
    assign serial_mode_out = mode_ff;

endmodule : ssfb_top

`default_nettype wire

// ### verif/ssfb_chk.sv
// assertion checker for the serial flash boot protocol engine
`timescale 1ns/1ps
`default_nettype none

module ssfb_chk
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // watched ports
    input wire logic handshake_busy_pin_in,
    input wire logic handshake_busy_pin_out,
    input wire logic handshake_busy_pin_oe_out,
    input wire logic serial_mode_out,
    input wire logic [23:0] flash_addr_out,
    input wire logic flash_rd_en_out,
    input wire logic flash_wr_en_out,
    input wire logic flash_erase_out,
    input wire logic flash_done_in
);
    // ------------------------------
    // pending flash operation
    // ------------------------------
    logic pend_ff;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    always_ff @(posedge sys_clk_in or negedge rstn_in)
        if (!rstn_in)
            pend_ff <= 1'b0;
        else if (flash_erase_out || (flash_wr_en_out && flash_addr_out[7:0] == 8'hFF))
            pend_ff <= 1'b1;
        else if (flash_done_in)
            pend_ff <= 1'b0;

    oe_mode_a: assert property (handshake_busy_pin_oe_out == serial_mode_out)
        else $error("oe not mode");
    mode_entry_a: assert property ($rose(serial_mode_out) |-> $past(handshake_busy_pin_in, 2))
        else $error("bad strap");
    read_mode_a: assert property (flash_rd_en_out |-> serial_mode_out)
        else $error("read off mode");
    wr_busy_a: assert property (flash_wr_en_out |-> handshake_busy_pin_out)
        else $error("write idle");
    wr_start_a: assert property ($rose(flash_wr_en_out) |-> flash_addr_out[7:0] == 8'h00 ##1
        (flash_wr_en_out && flash_addr_out[7:0] == 8'h01)) else $error("write start");
    wr_step_a: assert property (flash_wr_en_out && $past(flash_wr_en_out) |->
        flash_addr_out == $past(flash_addr_out) + 24'h00_0001) else $error("write order");
    erase_pulse_a: assert property (flash_erase_out |=> !flash_erase_out)
        else $error("erase long");
    op_busy_a: assert property (pend_ff |-> handshake_busy_pin_out)
        else $error("busy low");
    busy_drop_a: assert property (pend_ff && flash_done_in |-> ##[1:20] !handshake_busy_pin_out)
        else $error("busy stuck");

    cover property (flash_erase_out);
    cover property ($rose(flash_wr_en_out));
    cover property ($rose(serial_mode_out));
endmodule : ssfb_chk

bind ssfb_top ssfb_chk i_chk (.*);

`default_nettype wire

// ### verif/ssfb_prog_model.sv
// serial programmer model driving the transfer clock and data
`timescale 1ns/1ps
`default_nettype none

module ssfb_prog_model
(
    // clock
    input wire logic sys_clk_in,
    // link
    input wire logic busy_in,
    input wire logic tx_in,
    output logic sclk_out,
    output logic rx_out
);
    logic hung;

    initial
    begin
        sclk_out = 1'b1;
        rx_out = 1'b0;
        hung = 1'b0;
    end

    // clock idles high; off phase with the system clock on purpose
    task automatic xfer(input logic [7:0] wr_byte, output logic [7:0] rd_byte);
        int n;
        n = 0;
        repeat (4) @(posedge sys_clk_in);
        while (busy_in !== 1'b0 && n < 20000)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n == 20000)
            hung = 1'b1;
        #7;
        for (int i = 0; i < 8; i++)
        begin
            sclk_out = 1'b0;
            rx_out = wr_byte[i];
            #80;
            sclk_out = 1'b1;
            rd_byte[i] = tx_in;
            #80;
        end
        rx_out = ~rx_out;
    endtask : xfer
endmodule : ssfb_prog_model

`default_nettype wire

// ### verif/ssfb_top_test.sv
// self-checking bench for the serial flash boot protocol engine
`timescale 1ns/1ps
`default_nettype none

module ssfb_top_test
    import ssfb_pkg::*;
;
    // arbitrary stored identification code
    localparam logic [55:0] ID_CODE = 56'h01_0203_0405_0607;
    logic sys_clk_in, rstn_in, strap, sclk, rx, busy_line, tx, busy_out, oe, mode;
    logic reg_wr_in, reg_rd_in, flash_done_in, flash_fail_in, flash_blank_in, fail_next;
    logic rd_en, wr_en, erase;
    logic [7:0] fs, ls, reg_addr_in, flash_rd_data_in, wr_data, wr_mem [256];
    logic [15:0] wr_page;
    logic [23:0] addr;
    logic [31:0] reg_wdata_in, reg_rdata, rdata;
    int failures, checks_done, rd_cnt, erase_cnt, op_wait;

    initial
    begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    assign busy_line = oe ? busy_out : strap;

    ssfb_top i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .serial_clock_input_in(sclk),
        .serial_receive_pin_in(rx), .serial_transmit_pin_out(tx), .handshake_busy_pin_in(busy_line),
        .handshake_busy_pin_out(busy_out), .handshake_busy_pin_oe_out(oe), .flash_addr_out(addr),
        .flash_rd_en_out(rd_en), .flash_rd_data_in(flash_rd_data_in), .flash_wr_en_out(wr_en),
        .flash_wr_data_out(wr_data), .flash_erase_out(erase), .flash_done_in(flash_done_in),
        .flash_fail_in(flash_fail_in), .flash_blank_in(flash_blank_in), .flash_id_code_in(ID_CODE),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata), .serial_mode_out(mode));

    ssfb_prog_model i_prog (.sys_clk_in(sys_clk_in), .busy_in(busy_line), .tx_in(tx), .sclk_out(sclk),
        .rx_out(rx));

    // ------------------------------
    // flash array stand-in
    // ------------------------------
    always @(posedge sys_clk_in)
    begin
        flash_rd_data_in <= rd_en ? (addr[7:0] ^ addr[15:8] ^ addr[23:16]) : ~flash_rd_data_in;
        flash_done_in <= (op_wait == 1);
        flash_fail_in <= (op_wait == 1) && fail_next;
        op_wait <= (erase || (wr_en && addr[7:0] == 8'hFF)) ? 12 : (op_wait > 0 ? op_wait - 1 : 0);
        if (wr_en)
            {wr_page, wr_mem[addr[7:0]]} <= {addr[23:8], wr_data};
        rd_cnt <= rd_cnt + int'(rd_en);
        erase_cnt <= erase_cnt + int'(erase);
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : check

    task automatic send(input logic [7:0] b);
        logic [7:0] d;
        i_prog.xfer(b, d);
    endtask : send

    task automatic status(output logic [7:0] fs, output logic [7:0] ls);
        send(CMD_READ_STAT);
        i_prog.xfer(8'h00, fs);
        i_prog.xfer(8'h00, ls);
    endtask : status

    task automatic do_reset(input logic s);
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        strap <= s;
        repeat (8) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
    endtask : do_reset

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_locked();
        send(CMD_PAGE_READ);
        send(8'h12);
        send(CMD_ERASE_ALL);
        send(CMD_ERASE_CONF);
        status(fs, ls);
        check("rds", 0, rd_cnt);
        check("ers", 0, erase_cnt);
        check("fs", 8'h80, fs);
        check("ls", 8'h00, ls);
        send(CMD_VERSION);
        for (int k = 0; k < VER_BYTES; k++)
        begin
            i_prog.xfer(8'h00, fs);
            check("ver", 8'(64'h5356_3030_3030_3031 >> 8*k), fs);
        end
    endtask : t_locked

    task automatic t_regs();
        repeat (10) @(posedge sys_clk_in);
        reg_rd(REG_CTRL, rdata);
        check("ctrl", CTRL_RESET, rdata);
        reg_rd(REG_STAT, rdata);
        check("stat", 32'h0003_0080, rdata);
        reg_rd(8'h08, rdata);
        check("unmap", 32'h0000_0000, rdata);
    endtask : t_regs

    task automatic t_id(input logic [55:0] code, input logic [1:0] res);
        send(CMD_ID_CHECK);
        repeat (4) send(8'h07);
        for (int i = 0; i < ID_BYTES; i++)
            send(code[8*i +: 8]);
        status(fs, ls);
        check("id", res, ls[3:2]);
    endtask : t_id

    task automatic t_read();
        logic [7:0] d;
        send(CMD_PAGE_READ);
        send(8'h12);
        send(8'h34);
        for (int k = 0; k < PAGE_BYTES; k++)
        begin
            i_prog.xfer(8'h00, d);
            check("rd", k[7:0] ^ 8'h26, d);
        end
    endtask : t_read

    task automatic t_prog();
        fail_next = 1'b1;
        send(CMD_PAGE_PROG);
        send(8'h56);
        send(8'h00);
        for (int k = 0; k < PAGE_BYTES; k++)
            send(k[7:0] ^ 8'hA5);
        status(fs, ls);
        check("fs", 8'h90, fs);
        check("page", 16'h0056, wr_page);
        for (int k = 0; k < PAGE_BYTES; k++)
            check("wr", k[7:0] ^ 8'hA5, wr_mem[k]);
        send(CMD_CLR_STAT);
        status(fs, ls);
        check("fs", 8'h80, fs);
    endtask : t_prog

    task automatic t_nomode();
        do_reset(1'b0);
        repeat (20) @(posedge sys_clk_in);
        check("mode", 0, mode);
        check("oe", 0, oe);
        do_reset(1'b1);
    endtask : t_nomode

    task automatic t_erase();
        flash_blank_in <= 1'b1;
        reg_wr(REG_CTRL, 32'h0000_0000);
        send(CMD_ERASE_ALL);
        send(CMD_ERASE_CONF);
        reg_wr(REG_CTRL, 32'h0000_0001);
        send(CMD_ERASE_ALL);
        send(8'h00);
        check("ers", 0, erase_cnt);
        send(CMD_ERASE_ALL);
        send(CMD_ERASE_CONF);
        status(fs, ls);
        check("ers", 1, erase_cnt);
        check("fs", 8'hA0, fs);
        send(CMD_CLR_STAT);
        status(fs, ls);
        check("fs", 8'h80, fs);
    endtask : t_erase

    task automatic report_and_stop();
        if (i_prog.hung)
            failures++;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial
    begin
        {rstn_in, reg_wr_in, reg_rd_in, flash_done_in, flash_fail_in, flash_blank_in, fail_next} = '0;
        strap = 1'b1;
        {reg_addr_in, reg_wdata_in, flash_rd_data_in} = '0;
        {op_wait, rd_cnt, erase_cnt, failures, checks_done} = '0;
        do_reset(1'b1);
        t_locked();
        t_regs();
        t_id(ID_CODE ^ 56'h00_0000_0000_0100, ID_MISMATCH);
        t_id(ID_CODE, ID_VERIFIED);
        t_read();
        t_prog();
        t_nomode();
        t_erase();
        report_and_stop();
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk_in);
        failures++;
        report_and_stop();
    end
endmodule : ssfb_top_test

`default_nettype wire
